// File: nfcs_host.sv
// Purpose: host side sequencer driving a byte-wide NOR flash by its pins
// Assumes: one command at a time on the user port; pins are asynchronous
// Notes: identification and query reads end with an automatic reset write
`timescale 1ns/100ps
`default_nettype none
module nfcs_host (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // user command port
  input wire logic cmd_valid,
  input wire nfcs_pkg::nfcs_cmd_s cmd,
  output logic cmd_ready,
  output logic rsp_valid,
  output nfcs_pkg::nfcs_rsp_s rsp,
  output logic flash_busy,
  // flash pins
  output logic [20:0] flash_addr,
  output logic [7:0] flash_dq_out,
  output logic flash_dq_oe_n,
  input wire logic [7:0] flash_dq_in,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  input wire logic ready_busy_n
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WSET = 3'b001,
    ST_WLOW = 3'b010,
    ST_WHIGH = 3'b011,
    ST_RLOW = 3'b100,
    ST_REVAL = 3'b101,
    ST_RESP = 3'b110
  } nfcs_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // command tables

  function automatic logic [2:0] nfcs_nwr(input nfcs_pkg::nfcs_op_e op);
    case (op)
      nfcs_pkg::OP_READ: nfcs_nwr = 3'h0;
      nfcs_pkg::OP_RESET, nfcs_pkg::OP_QUERY,
      nfcs_pkg::OP_SUSPEND, nfcs_pkg::OP_RESUME: nfcs_nwr = 3'h1;
      nfcs_pkg::OP_BYP_PROGRAM, nfcs_pkg::OP_BYP_EXIT: nfcs_nwr = 3'h2;
      nfcs_pkg::OP_IDENT, nfcs_pkg::OP_BYP_ENTER: nfcs_nwr = 3'h3;
      nfcs_pkg::OP_PROGRAM: nfcs_nwr = 3'h4;
      default: nfcs_nwr = 3'h6;
    endcase
  endfunction

  function automatic nfcs_pkg::nfcs_wcyc_s nfcs_wr(
    input nfcs_pkg::nfcs_op_e op,
    input logic [2:0] step,
    input logic [20:0] addr,
    input logic [7:0] data
  );
    nfcs_pkg::nfcs_wcyc_s w;
    w.addr = nfcs_pkg::UNLOCK_ADDR1;
    w.data = nfcs_pkg::CMD_RESET;
    case (op)
      nfcs_pkg::OP_QUERY:
      begin
        w.addr = nfcs_pkg::QUERY_ADDR;
        w.data = nfcs_pkg::CMD_QUERY;
      end
      nfcs_pkg::OP_SUSPEND: w.data = nfcs_pkg::CMD_SUSPEND;
      nfcs_pkg::OP_RESUME: w.data = nfcs_pkg::CMD_RESUME;
      nfcs_pkg::OP_BYP_PROGRAM:
        if (step == 3'h0)
        begin
          w.data = nfcs_pkg::CMD_PROGRAM;
        end
        else
        begin
          w.addr = addr;
          w.data = data;
        end
      nfcs_pkg::OP_BYP_EXIT:
        w.data = (step == 3'h0) ? nfcs_pkg::CMD_IDENT
                                : nfcs_pkg::CMD_BYPASS_EXIT;
      default:
        case (step)
          3'h0: w.data = nfcs_pkg::CMD_UNLOCK1;
          3'h1:
          begin
            w.addr = nfcs_pkg::UNLOCK_ADDR2;
            w.data = nfcs_pkg::CMD_UNLOCK2;
          end
          3'h2:
            case (op)
              nfcs_pkg::OP_IDENT: w.data = nfcs_pkg::CMD_IDENT;
              nfcs_pkg::OP_PROGRAM: w.data = nfcs_pkg::CMD_PROGRAM;
              nfcs_pkg::OP_BYP_ENTER: w.data = nfcs_pkg::CMD_BYPASS;
              default: w.data = nfcs_pkg::CMD_ERASE_SETUP;
            endcase
          3'h3:
            if (op == nfcs_pkg::OP_PROGRAM)
            begin
              w.addr = addr;
              w.data = data;
            end
            else
            begin
              w.data = nfcs_pkg::CMD_UNLOCK1;
            end
          3'h4:
          begin
            w.addr = nfcs_pkg::UNLOCK_ADDR2;
            w.data = nfcs_pkg::CMD_UNLOCK2;
          end
          default:
            if (op == nfcs_pkg::OP_SECT_ERASE)
            begin
              w.addr = addr;
              w.data = nfcs_pkg::CMD_SECTOR_ERASE;
            end
            else
            begin
              w.data = nfcs_pkg::CMD_CHIP_ERASE;
            end
        endcase
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [7:0] dq_sync;
  logic busy_sync;

  nfcs_sync #(.W(8)) u_dq_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(flash_dq_in),
    .sync_out(dq_sync)
  );

  // synchronised as busy, so the reset value matches the pulled-up idle pin
  nfcs_sync #(.W(1)) u_rb_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(~ready_busy_n),
    .sync_out(busy_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  nfcs_state_e state, next_state;
  nfcs_pkg::nfcs_cmd_s cur, next_cur;
  logic [2:0] step, next_step;
  logic [7:0] cnt, next_cnt;
  logic final_rd, next_final_rd;
  logic recheck, next_recheck;
  logic abort, next_abort;
  logic cleanup, next_cleanup;
  logic next_cmd_ready, next_rsp_valid, next_flash_busy;
  nfcs_pkg::nfcs_rsp_s next_rsp;
  logic [20:0] next_flash_addr;
  logic [7:0] next_flash_dq_out;
  logic next_dq_oe_n, next_ce_n, next_we_n, next_oe_n;

  nfcs_pkg::nfcs_wcyc_s wcur;
  logic is_poll, is_erase, poll_done;

  always_comb
  begin
    wcur = nfcs_wr(cur.op, step, cur.addr, cur.data);
    if (abort || cleanup)
    begin
      wcur.addr = nfcs_pkg::UNLOCK_ADDR1;
      wcur.data = nfcs_pkg::CMD_RESET;
    end
    is_erase = (cur.op == nfcs_pkg::OP_CHIP_ERASE) ||
               (cur.op == nfcs_pkg::OP_SECT_ERASE);
    is_poll = is_erase || (cur.op == nfcs_pkg::OP_PROGRAM) ||
              (cur.op == nfcs_pkg::OP_BYP_PROGRAM);
    // erase completes to 1, program to the true written bit
    poll_done = is_erase ? dq_sync[nfcs_pkg::POLL_BIT]
              : (dq_sync[nfcs_pkg::POLL_BIT] ==
                 cur.data[nfcs_pkg::POLL_BIT]);
  end

  always_comb
  begin
    next_state = state;
    next_cur = cur;
    next_step = step;
    next_cnt = cnt;
    next_final_rd = final_rd;
    next_recheck = recheck;
    next_abort = abort;
    next_cleanup = cleanup;
    next_rsp = rsp;
    next_rsp_valid = 1'b0;
    next_flash_busy = busy_sync;
    next_flash_addr = flash_addr;
    next_flash_dq_out = flash_dq_out;
    next_dq_oe_n = flash_dq_oe_n;
    next_ce_n = flash_ce_n;
    next_we_n = flash_we_n;
    next_oe_n = flash_oe_n;
    case (state)
      ST_IDLE:
        if (cmd_valid)
        begin
          next_cur = cmd;
          next_step = 3'h0;
          next_final_rd = 1'b0;
          next_recheck = 1'b0;
          next_abort = 1'b0;
          next_cleanup = 1'b0;
          next_rsp = '0;
          if (cmd.op == nfcs_pkg::OP_READ)
          begin
            next_final_rd = 1'b1;
            next_state = ST_RLOW;
            next_cnt = nfcs_pkg::RD_CYC;
            next_flash_addr = cmd.addr;
            next_ce_n = 1'b0;
            next_oe_n = 1'b0;
          end
          else
          begin
            next_state = ST_WSET;
          end
        end
      ST_WSET:
      begin
        // every command byte goes out as a write cycle
        next_flash_addr = wcur.addr;
        next_flash_dq_out = wcur.data;
        next_dq_oe_n = 1'b0;
        next_ce_n = 1'b0;
        next_we_n = 1'b0;
        next_cnt = nfcs_pkg::WP_CYC;
        next_state = ST_WLOW;
      end
      ST_WLOW:
        if (cnt == 8'h01)
        begin
          next_we_n = 1'b1;
          next_ce_n = 1'b1;
          next_cnt = nfcs_pkg::WPH_CYC;
          next_state = ST_WHIGH;
        end
        else
        begin
          next_cnt = cnt - 8'h01;
        end
      ST_WHIGH:
        if (cnt != 8'h01)
        begin
          next_cnt = cnt - 8'h01;
        end
        else
        begin
          // data held past the rising edge, then released
          next_dq_oe_n = 1'b1;
          if (abort || cleanup)
          begin
            next_state = ST_RESP;
          end
          else if (step + 3'h1 < nfcs_nwr(cur.op))
          begin
            next_step = step + 3'h1;
            next_state = ST_WSET;
          end
          else if (is_poll || cur.op == nfcs_pkg::OP_IDENT ||
                   cur.op == nfcs_pkg::OP_QUERY)
          begin
            // poll begins WPH_CYC clocks after the final rising write edge, as the data is released
            next_final_rd = ~is_poll;
            next_state = ST_RLOW;
            next_cnt = nfcs_pkg::RD_CYC;
            next_flash_addr = cur.addr;
            next_ce_n = 1'b0;
            next_oe_n = 1'b0;
          end
          else
          begin
            next_state = ST_RESP;
          end
        end
      ST_RLOW:
        if (cnt == 8'h01)
        begin
          next_state = ST_REVAL;
        end
        else
        begin
          next_cnt = cnt - 8'h01;
        end
      ST_REVAL:
      begin
        // strobes rise between reads so each is a fresh read cycle
        next_ce_n = 1'b1;
        next_oe_n = 1'b1;
        next_cnt = nfcs_pkg::RD_CYC;
        next_state = ST_RLOW;
        if (final_rd)
        begin
          next_rsp.data = dq_sync;
          if (cur.op == nfcs_pkg::OP_IDENT || cur.op == nfcs_pkg::OP_QUERY)
          begin
            next_cleanup = 1'b1;
            next_state = ST_WSET;
          end
          else
          begin
            next_state = ST_RESP;
          end
        end
        else if (poll_done)
        begin
          // top bit may settle apart from the rest: read once more
          next_final_rd = 1'b1;
        end
        else if (recheck)
        begin
          next_abort = 1'b1;
          next_rsp.err = 1'b1;
          next_state = ST_WSET;
        end
        else if (dq_sync[nfcs_pkg::TIMEOUT_BIT])
        begin
          next_recheck = 1'b1;
        end
      end
      ST_RESP:
      begin
        // chip erase swallows commands, so none goes out before done
        next_rsp_valid = 1'b1;
        next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    // cycle a strobe high for one clock before the next read
    if (state == ST_REVAL && next_state == ST_RLOW)
    begin
      next_state = ST_RLOW;
    end
    next_cmd_ready = (next_state == ST_IDLE);
  end

  // the extra strobe-high cycle between reads
  logic gap, next_gap;

  always_comb
  begin
    next_gap = (state == ST_REVAL) && (next_state == ST_RLOW);
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      cur <= '0;
      step <= 3'h0;
      cnt <= 8'h00;
      final_rd <= 1'b0;
      recheck <= 1'b0;
      abort <= 1'b0;
      cleanup <= 1'b0;
      gap <= 1'b0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp <= '0;
      flash_busy <= 1'b0;
      flash_addr <= 21'h000000;
      flash_dq_out <= 8'h00;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n <= 1'b1;
      flash_we_n <= 1'b1;
      flash_oe_n <= 1'b1;
    end
    else
    begin
      state <= next_state;
      cur <= next_cur;
      step <= next_step;
      cnt <= next_cnt;
      final_rd <= next_final_rd;
      recheck <= next_recheck;
      abort <= next_abort;
      cleanup <= next_cleanup;
      gap <= next_gap;
      cmd_ready <= next_cmd_ready;
      rsp_valid <= next_rsp_valid;
      rsp <= next_rsp;
      flash_busy <= next_flash_busy;
      flash_addr <= next_flash_addr;
      flash_dq_out <= next_flash_dq_out;
      flash_dq_oe_n <= next_dq_oe_n;
      // drive strobes low again after their one high cycle between reads
      flash_ce_n <= gap ? 1'b0 : next_ce_n;
      flash_we_n <= next_we_n;
      flash_oe_n <= gap ? 1'b0 : next_oe_n;
    end
  end

endmodule
`default_nettype wire

// File: nfcs_pkg.sv
// Purpose: shared types and constants of the NOR flash command sequencer
// Assumes: byte-wide flash, 21 address bits, host clock mclk at 125 MHz
// Notes: pin timing figures are plain defaults, tune for the part in use
package nfcs_pkg;

  localparam int ADDR_W = 21;
  localparam int DATA_W = 8;

  // command bytes written on the data pins
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_QUERY = 8'h98;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_BYPASS_EXIT = 8'h00;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'h30;

  // unlock addresses are don't care; these are conventional picks
  localparam logic [20:0] UNLOCK_ADDR1 = 21'h000555;
  localparam logic [20:0] UNLOCK_ADDR2 = 21'h0002AA;
  localparam logic [20:0] QUERY_ADDR = 21'h000055;

  // status bit positions on the data pins
  localparam int POLL_BIT = 7;
  localparam int TIMEOUT_BIT = 5;

  // pin timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int T_WP_NS = 35;
  localparam int T_WPH_NS = 30;
  localparam int T_ACC_NS = 70;
  localparam int SYNC_STAGES = 2;
  localparam logic [7:0] WP_CYC =
    8'((T_WP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] WPH_CYC =
    8'((T_WPH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [7:0] RD_CYC =
    8'((T_ACC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + SYNC_STAGES);

  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_RESET = 4'h1,
    OP_IDENT = 4'h2,
    OP_QUERY = 4'h3,
    OP_PROGRAM = 4'h4,
    OP_BYP_ENTER = 4'h5,
    OP_BYP_PROGRAM = 4'h6,
    OP_BYP_EXIT = 4'h7,
    OP_CHIP_ERASE = 4'h8,
    OP_SECT_ERASE = 4'h9,
    OP_SUSPEND = 4'hA,
    OP_RESUME = 4'hB
  } nfcs_op_e;

  typedef struct packed {
    nfcs_op_e op;
    logic [20:0] addr;
    logic [7:0] data;
  } nfcs_cmd_s;

  typedef struct packed {
    logic err;
    logic [7:0] data;
  } nfcs_rsp_s;

  typedef struct packed {
    logic [20:0] addr;
    logic [7:0] data;
  } nfcs_wcyc_s;

endpackage

// File: nfcs_sync.sv
// Purpose: two flip-flop synchroniser for pins entering mclk
// Assumes: bits of a bus are only read once they have settled
// Notes: first stage feeds the second stage only
`timescale 1ns/100ps
`default_nettype none
module nfcs_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // asynchronous level in, synchronised level out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule
`default_nettype wire

// File: nfcs_host_sva.sv
// Purpose: pin and handshake checks on the flash host sequencer
// Assumes: WP_CYC 5, WPH_CYC 4, three-stage busy path
// Notes: bound from the testbench top file
`timescale 1ns/100ps
`default_nettype none
module nfcs_host_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // user port
  input wire logic cmd_valid,
  input wire nfcs_pkg::nfcs_cmd_s cmd,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire nfcs_pkg::nfcs_rsp_s rsp,
  input wire logic flash_busy,
  // flash pins
  input wire logic [20:0] flash_addr,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe_n,
  input wire logic [7:0] flash_dq_in,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic ready_busy_n
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
////////////////////////////////////////
  property p_we_width;
    $fell(flash_we_n) |-> (!flash_we_n)[*5] ##1 flash_we_n;
  endproperty
  a_we_width: assert property (p_we_width) else $error("we width");
  property p_data_hold;
    $rose(flash_we_n) |-> (!flash_dq_oe_n && $stable(flash_dq_out))[*4];
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("hold");
  property p_write_pins;
    !flash_we_n |-> !flash_ce_n && flash_oe_n && !flash_dq_oe_n;
  endproperty
  a_write_pins: assert property (p_write_pins) else $error("write");
  property p_read_pins;
    $fell(flash_oe_n) |-> (!flash_ce_n && flash_we_n && flash_dq_oe_n)[*8];
  endproperty
  a_read_pins: assert property (p_read_pins) else $error("read");
  property p_idle;
    cmd_ready |-> flash_ce_n && flash_we_n && flash_oe_n;
  endproperty
  a_idle: assert property (p_idle) else $error("pins active in idle");
  property p_rsp;
    rsp_valid |=> !rsp_valid && cmd_ready;
  endproperty
  a_rsp: assert property (p_rsp) else $error("response pulse");
  property p_busy_on;
    (!ready_busy_n)[*4] |-> flash_busy;
  endproperty
  a_busy_on: assert property (p_busy_on) else $error("busy lost");
  property p_busy_off;
    ready_busy_n[*4] |-> !flash_busy;
  endproperty
  a_busy_off: assert property (p_busy_off) else $error("busy stuck");
  c_busy: cover property ($fell(ready_busy_n));
  c_read: cover property ($fell(flash_oe_n));
  c_erased: cover property (rsp_valid && rsp.data == 8'hFF);
endmodule
`default_nettype wire

// File: nfcs_flash_model.sv
// Purpose: behavioural byte-wide NOR flash for the host sequencer bench
// Assumes: one protected sector, erased bytes read FF
// Notes: embedded operation times are shortened stand-ins
`timescale 1ns/100ps
`default_nettype none
module nfcs_flash_model #(
  parameter logic [7:0] MAKER_CODE = 8'h3D, // arbitrary value
  parameter logic [7:0] PART_CODE = 8'h6E, // arbitrary value
  parameter logic [7:0] QUERY_BYTE = 8'h51,
  parameter logic [4:0] PROT_SEC = 5'h1F,
  parameter int PROG_NS = 2000,
  parameter int ERASE_NS = 20000
) (
  // pins from the host
  input wire logic [20:0] flash_addr,
  input wire logic [7:0] flash_dq_out,
  input wire logic flash_dq_oe_n,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  // pins to the host
  output logic [7:0] flash_dq_in,
  output logic ready_busy_n
);
  logic [7:0] mem [logic [20:0]];
  logic [20:0] la, prog_at;
  logic [7:0] prog_val = 8'h00;
  logic [4:0] ers_sec = 5'h00;
  logic bsy = 1'b0, ers = 1'b0, chp = 1'b0, sus = 1'b0, byp = 1'b0;
  int st = 0, md = 0;
  realtime fin;
////////////////////////////////////////
  task automatic go(input logic e, input logic c, input int ns);
    ers = e;
    chp = c;
    bsy = 1'b1;
    fin = $realtime + ns;
  endtask
  task automatic wr(input logic [20:0] a, input logic [7:0] d);
    int n;
    n = 0;
    if (bsy)
    begin
      // suspend lands at once, window or not
      sus = ers && !chp && d == 8'hB0;
      bsy = !sus;
      return;
    end
    case (st)
      0: if (byp)
        n = (d == 8'hA0) ? 3 : (d == 8'h90) ? 7 : 0;
      else if (d == 8'hF0) md = 0;
      else if (d == 8'hAA) n = 1;
      else if (d == 8'h98 && a[7:0] == 8'h55 && md < 2) md = 2;
      else if (d == 8'h30 && sus)
      begin
        sus = 1'b0;
        go(1'b1, 1'b0, ERASE_NS);
      end
      else if (d != 8'hB0) n = 9;
      1: n = (d == 8'h55) ? 2 : 9;
      2: case (d)
        8'h90: md = 1;
        8'hA0: n = 3;
        8'h20: byp = 1'b1;
        8'h80: n = 4;
        default: n = 9;
      endcase
      3:
      begin
        prog_at = a;
        prog_val = d;
        go(1'b0, 1'b0, a[20:16] == PROT_SEC ? 1000 : PROG_NS);
      end
      4: n = (d == 8'hAA) ? 5 : 9;
      5: n = (d == 8'h55) ? 6 : 9;
      6: if (d == 8'h10) go(1'b1, 1'b1, ERASE_NS);
      else if (d == 8'h30)
      begin
        ers_sec = a[20:16];
        go(1'b1, 1'b0, ers_sec == PROT_SEC ? 100000 : ERASE_NS);
      end
      else n = 9;
      7: if (d == 8'h00) byp = 1'b0;
      else n = 9;
      default: n = 9;
    endcase
    if (n == 9) md = 0;
    st = (n == 9) ? 0 : n;
  endtask
  function automatic logic [7:0] rdv(input logic [20:0] a);
    if (bsy) return ers ? 8'h00 : {~prog_val[7], 7'h00};
    if (sus && a[20:16] == ers_sec) return 8'h80;
    if (md == 1)
      return (a[7:0] == 8'h00) ? MAKER_CODE : (a[7:0] == 8'h01) ? PART_CODE
        : {7'h00, a[20:16] == PROT_SEC};
    if (md == 2) return QUERY_BYTE;
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
////////////////////////////////////////
  // protected places are never written or erased
  always #8 if (bsy && $realtime >= fin)
  begin
    if (!ers && prog_at[20:16] != PROT_SEC)
      mem[prog_at] = prog_val;
    if (ers)
      foreach (mem[k])
        if ((chp || k[20:16] == ers_sec) && k[20:16] != PROT_SEC)
          mem[k] = 8'hFF;
    bsy = 1'b0;
  end
  initial flash_dq_in = 8'h00;
  // a released bus keeps changing, never the last value
  always #2 flash_dq_in = (!flash_ce_n && !flash_oe_n) ?
    rdv(flash_addr) : ~flash_dq_in;
  assign ready_busy_n = !bsy;
  always @(negedge flash_we_n) la = flash_addr;
  always @(posedge flash_we_n) if (!flash_dq_oe_n) wr(la, flash_dq_out);
endmodule
`default_nettype wire

// File: nfcs_host_test.sv
// Purpose: self-checking bench for the flash host sequencer
// Assumes: flash model on the pins, pull-up folded into the model
// Notes: suspend is only tried while idle, where it must be ignored
`timescale 1ns/100ps
`default_nettype none
module nfcs_host_test;
  localparam logic [7:0] MAKER = 8'h3D; // arbitrary value
  localparam logic [7:0] PART = 8'h6E; // arbitrary value
  localparam logic [7:0] QRY = 8'h51;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid = 1'b0;
  nfcs_pkg::nfcs_cmd_s cmd = '0;
  nfcs_pkg::nfcs_rsp_s rsp;
  logic cmd_ready, rsp_valid, flash_busy, flash_dq_oe_n, ready_busy_n;
  logic flash_ce_n, flash_we_n, flash_oe_n;
  logic [20:0] flash_addr;
  logic [7:0] flash_dq_out, flash_dq_in;
  int mismatches = 0;
  int checks = 0;
  nfcs_host DUT (.mclk(mclk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp(rsp),
    .flash_busy(flash_busy), .flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
    .flash_dq_in(flash_dq_in), .flash_ce_n(flash_ce_n),
    .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
    .ready_busy_n(ready_busy_n));
  nfcs_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART),
    .QUERY_BYTE(QRY)) u_flash (.flash_addr(flash_addr),
    .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n),
    .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
    .flash_oe_n(flash_oe_n), .flash_dq_in(flash_dq_in),
    .ready_busy_n(ready_busy_n));
////////////////////////////////////////
  task automatic test_done;
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [8:0] s, input logic [8:0] e);
    checks++;
    if (s !== e)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic run(input nfcs_pkg::nfcs_op_e op, input logic [20:0] a,
    input logic [7:0] d, input logic ck, input logic [8:0] e);
    int n;
    @(negedge mclk);
    while (cmd_ready !== 1'b1) @(negedge mclk);
    cmd_valid = 1'b1;
    cmd = '{op, a, d};
    @(negedge mclk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20000)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 20000) mismatches++;
    if (ck) check(rsp, e);
  endtask
////////////////////////////////////////
  initial forever #4 mclk = ~mclk;
  initial
  begin
    repeat (60000) @(posedge mclk);
    mismatches++;
    test_done;
  end
  initial
  begin
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    run(nfcs_pkg::OP_READ, 21'h010005, 8'h00, 1'h1, 9'h0FF);
    run(nfcs_pkg::OP_PROGRAM, 21'h010005, 8'h3C, 1'h1, 9'h03C);
    run(nfcs_pkg::OP_READ, 21'h010005, 8'h00, 1'h1, 9'h03C);
    run(nfcs_pkg::OP_IDENT, 21'h000000, 8'h00, 1'h1, {1'h0, MAKER});
    run(nfcs_pkg::OP_IDENT, 21'h000001, 8'h00, 1'h1, {1'h0, PART});
    run(nfcs_pkg::OP_IDENT, 21'h1F0002, 8'h00, 1'h1, 9'h001);
    run(nfcs_pkg::OP_IDENT, 21'h010002, 8'h00, 1'h1, 9'h000);
    run(nfcs_pkg::OP_READ, 21'h010005, 8'h00, 1'h1, 9'h03C);
    run(nfcs_pkg::OP_QUERY, 21'h000010, 8'h00, 1'h1, {1'h0, QRY});
    run(nfcs_pkg::OP_READ, 21'h010005, 8'h00, 1'h1, 9'h03C);
    run(nfcs_pkg::OP_PROGRAM, 21'h1F0010, 8'hA5, 1'h1, 9'h0FF);
    run(nfcs_pkg::OP_BYP_ENTER, 21'h000000, 8'h00, 1'h0, 9'h000);
    run(nfcs_pkg::OP_BYP_PROGRAM, 21'h030001, 8'h5A, 1'h1, 9'h05A);
    run(nfcs_pkg::OP_BYP_PROGRAM, 21'h030002, 8'h0F, 1'h1, 9'h00F);
    run(nfcs_pkg::OP_BYP_EXIT, 21'h000000, 8'h00, 1'h0, 9'h000);
    run(nfcs_pkg::OP_READ, 21'h030002, 8'h00, 1'h1, 9'h00F);
    run(nfcs_pkg::OP_SECT_ERASE, 21'h010000, 8'h00, 1'h1, 9'h0FF);
    run(nfcs_pkg::OP_READ, 21'h010005, 8'h00, 1'h1, 9'h0FF);
    run(nfcs_pkg::OP_READ, 21'h030001, 8'h00, 1'h1, 9'h05A);
    run(nfcs_pkg::OP_SECT_ERASE, 21'h1F0000, 8'h00, 1'h1, 9'h0FF);
    run(nfcs_pkg::OP_CHIP_ERASE, 21'h000000, 8'h00, 1'h1, 9'h0FF);
    run(nfcs_pkg::OP_READ, 21'h030001, 8'h00, 1'h1, 9'h0FF);
    run(nfcs_pkg::OP_RESET, 21'h000000, 8'h00, 1'h0, 9'h000);
    run(nfcs_pkg::OP_SUSPEND, 21'h000000, 8'h00, 1'h0, 9'h000);
    run(nfcs_pkg::OP_RESUME, 21'h000000, 8'h00, 1'h0, 9'h000);
    run(nfcs_pkg::OP_PROGRAM, 21'h020000, 8'h80, 1'h1, 9'h080);
    test_done;
  end
endmodule
bind nfcs_host nfcs_host_sva u_sva (.mclk(mclk), .rst_n(rst_n),
  .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
  .rsp_valid(rsp_valid), .rsp(rsp), .flash_busy(flash_busy),
  .flash_addr(flash_addr), .flash_dq_out(flash_dq_out),
  .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_in(flash_dq_in),
  .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n),
  .flash_oe_n(flash_oe_n), .ready_busy_n(ready_busy_n));
`default_nettype wire
